// ===== core/pin_share_pkg.sv
package pin_share_pkg;

    // Port mode selection
    typedef enum logic [1:0] {
        MODE_PRINTER,
        MODE_EXT_SINGLE,
        MODE_EXT_DUAL
    } port_mode_t;

    localparam int CFG_W = 8;
    localparam logic [CFG_W-1:0] CFG_EXT_SEL = 8'h03;
    localparam int PULLUP_OFF_BIT = 7;
    localparam int EXT_DUAL_BIT = 0;

    // Printer control pins, shared with floppy outputs
    localparam int CTL_W = 9;
    localparam int CTL_SELECT = 0;
    localparam int CTL_PAPER_END = 1;
    localparam int CTL_BUSY = 2;
    localparam int CTL_ACK = 3;
    localparam int CTL_ERROR = 4;
    localparam int CTL_SELECT_IN = 5;
    localparam int CTL_INIT = 6;
    localparam int CTL_AUTOFEED = 7;
    localparam int CTL_STROBE = 8;

    // Printer core drive requests (active high)
    localparam int PCTL_W = 4;
    localparam int PCTL_SELECT_IN = 0;
    localparam int PCTL_INIT = 1;
    localparam int PCTL_AUTOFEED = 2;
    localparam int PCTL_STROBE = 3;

    // Floppy controller requests and native outputs
    localparam int FO_W = 10;
    localparam int FO_DENSITY0 = 0;
    localparam int FO_HEAD = 1;
    localparam int FO_WGATE = 2;
    localparam int FO_WSTREAM = 3;
    localparam int FO_STEP = 4;
    localparam int FO_SEEK = 5;
    localparam int FO_MOTOR_B = 6;
    localparam int FO_SEL_A = 7;
    localparam int FO_SEL_B = 8;
    localparam int FO_MOTOR_A = 9;

    // Floppy status lines; index equals shared data bit
    localparam int ST_W = 5;
    localparam int ST_INDEX = 0;
    localparam int ST_TRACK_ZERO = 1;
    localparam int ST_WPROT = 2;
    localparam int ST_READ = 3;
    localparam int ST_MEDIA_CHG = 4;

    // Printer status to the printer core
    localparam int PS_W = 5;

    localparam int PD_W = 8;
    localparam int PD_MOTOR_A = 6;
    localparam int PD_SEL_A = 7;

    localparam int SYNC_W = PD_W + CTL_W + ST_W;
    localparam logic [SYNC_W-1:0] SYNC_RST = '1;
    localparam logic [ST_W-1:0] ST_IDLE = 5'h1f;
    localparam logic [PS_W-1:0] PS_RST = 5'h18;

endpackage

// ===== core/pin_sync2.sv
`timescale 1ns/1ps

// Two-stage synchroniser for pin inputs
module pin_sync2
    import pin_share_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage read only by second stage
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule

// ===== core/printer_port_floppy_pin_share.sv
// Contract
// - Printer mode: eight pins are data bits
// - External mode: bit 1 carries track zero
// - External mode: bit 2 carries write protect
// - External mode: bit 3 carries read data
// - External mode: bit 4 carries media changed
// - Unused external pins float: 5; 6,7 single
// - Dual mode: bit 6 drives motor A
// - Dual mode: bit 7 drives select A
// - Single serves drive B; dual both
// - External floppy inputs pulled high internally
// - Head pin high side 0, low side 1
// - Seek pin high outward, low inward
// - Motor and select pins active-low open-drain
// - One low step pulse per track
// - Write data active low to drive
// - Config bit 7 turns pull-ups off
// - Mode comes from both config sources
// - External mode: bit 0 carries index
// - Control pins copy floppy outputs externally
`timescale 1ns/1ps

module printer_port_floppy_pin_share
    import pin_share_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [CFG_W-1:0] port_mode_cfg,
    input wire logic [CFG_W-1:0] port_mode_cfg_ext,
    input wire logic [CFG_W-1:0] floppy_cfg_reg,
    input wire logic [PD_W-1:0] prn_data_out,
    input wire logic prn_data_drive,
    input wire logic [PCTL_W-1:0] prn_ctl_req,
    output logic [PD_W-1:0] prn_data_in,
    output logic [PS_W-1:0] prn_status,
    input wire logic [FO_W-1:0] fdc_req,
    output logic [ST_W-1:0] fdc_status_n,
    input wire logic [PD_W-1:0] pd_in,
    output logic [PD_W-1:0] pd_out,
    output logic [PD_W-1:0] pd_oe,
    output logic [PD_W-1:0] pd_pullup_en,
    input wire logic [CTL_W-1:0] ctl_in,
    output logic [CTL_W-1:0] ctl_out,
    output logic [CTL_W-1:0] ctl_oe,
    output logic [FO_W-1:0] fdd_out,
    output logic [FO_W-1:0] fdd_oe,
    input wire logic [ST_W-1:0] fdd_status_in,
    output logic fdd_pullup_en,
    output logic [1:0] port_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Mode decode

    // Config pair to pin mode
    function automatic port_mode_t decode_mode(
        input logic [CFG_W-1:0] cfg,
        input logic [CFG_W-1:0] ext
    );
        port_mode_t m;
        m = MODE_PRINTER;
        if (cfg == CFG_EXT_SEL && ext[EXT_DUAL_BIT])
        begin
            m = MODE_EXT_DUAL;
        end
        else if (cfg == CFG_EXT_SEL)
        begin
            m = MODE_EXT_SINGLE;
        end
        return m;
    endfunction

    port_mode_t mode_q;
    port_mode_t mode_d;
    logic pullup_off_q;
    logic pullup_off_d;

    // Next mode from both config sources
    always_comb
    begin
        mode_d = decode_mode(port_mode_cfg, port_mode_cfg_ext);
        pullup_off_d = floppy_cfg_reg[PULLUP_OFF_BIT];
    end

    // Mode registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            mode_q <= MODE_PRINTER;
            pullup_off_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            pullup_off_q <= pullup_off_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers

    logic [SYNC_W-1:0] sync_out;
    logic [PD_W-1:0] pd_s;
    logic [CTL_W-1:0] ctl_s;
    logic [ST_W-1:0] fdd_s;

    pin_sync2 #(
        .W(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din({fdd_status_in, ctl_in, pd_in}),
        .dout(sync_out)
    );

    // Split synchronised pins
    assign pd_s = sync_out[PD_W-1:0];
    assign ctl_s = sync_out[PD_W+CTL_W-1:PD_W];
    assign fdd_s = sync_out[SYNC_W-1:PD_W+CTL_W];

    ////////////////////////////////////////////////////////////////////////
    // Floppy pin levels

    // Active-high request to open-drain low level
    function automatic logic od_level(input logic req);
        return ~req;
    endfunction

    logic [FO_W-1:0] lvl;
    logic ext_mode;
    logic dual_mode;

    // Controller requests to pin levels
    always_comb
    begin
        lvl = '1;
        lvl[FO_DENSITY0] = od_level(fdc_req[FO_DENSITY0]);
        lvl[FO_HEAD] = od_level(fdc_req[FO_HEAD]); // Side 1 pulls low
        lvl[FO_WGATE] = od_level(fdc_req[FO_WGATE]);
        lvl[FO_WSTREAM] = od_level(fdc_req[FO_WSTREAM]);
        lvl[FO_STEP] = od_level(fdc_req[FO_STEP]); // Pulse passes 1:1
        lvl[FO_SEEK] = od_level(fdc_req[FO_SEEK]); // Inward pulls low
        lvl[FO_MOTOR_B] = od_level(fdc_req[FO_MOTOR_B]);
        lvl[FO_SEL_A] = od_level(fdc_req[FO_SEL_A]);
        lvl[FO_SEL_B] = od_level(fdc_req[FO_SEL_B]);
        lvl[FO_MOTOR_A] = od_level(fdc_req[FO_MOTOR_A]);
    end

    assign ext_mode = (mode_q != MODE_PRINTER);
    assign dual_mode = (mode_q == MODE_EXT_DUAL);

    ////////////////////////////////////////////////////////////////////////
    // Native floppy outputs

    logic [FO_W-1:0] fdd_oe_q;
    logic [FO_W-1:0] fdd_oe_d;

    // Open-drain: enable while pulling low
    always_comb
    begin
        fdd_oe_d = ~lvl;
    end

    // Native output registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            fdd_oe_q <= '0;
        end
        else
        begin
            fdd_oe_q <= fdd_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared data pins

    logic [PD_W-1:0] pd_out_q;
    logic [PD_W-1:0] pd_out_d;
    logic [PD_W-1:0] pd_oe_q;
    logic [PD_W-1:0] pd_oe_d;
    logic [PD_W-1:0] pd_pu_q;
    logic [PD_W-1:0] pd_pu_d;

    // Data pin drivers by mode
    always_comb
    begin
        pd_out_d = '0;
        pd_oe_d = '0;
        pd_pu_d = '0;
        if (!ext_mode)
        begin
            pd_out_d = prn_data_out;
            pd_oe_d = {PD_W{prn_data_drive}};
        end
        else
        begin
            // Bits 0..4 become pulled-up floppy inputs
            pd_pu_d[ST_W-1:0] = {ST_W{~pullup_off_q}};
            // Bit 5 floats in both modes, 6 and 7 in single
            pd_oe_d[ST_W] = 1'b0;
            if (dual_mode)
            begin
                pd_oe_d[PD_MOTOR_A] = ~lvl[FO_MOTOR_A];
                pd_oe_d[PD_SEL_A] = ~lvl[FO_SEL_A];
            end
        end
    end

    // Data pin registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pd_out_q <= '0;
            pd_oe_q <= '0;
            pd_pu_q <= '0;
        end
        else
        begin
            pd_out_q <= pd_out_d;
            pd_oe_q <= pd_oe_d;
            pd_pu_q <= pd_pu_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared control pins

    logic [CTL_W-1:0] ctl_oe_q;
    logic [CTL_W-1:0] ctl_oe_d;

    // Control pin drivers by mode
    always_comb
    begin
        ctl_oe_d = '0;
        if (!ext_mode)
        begin
            ctl_oe_d[CTL_SELECT_IN] = prn_ctl_req[PCTL_SELECT_IN];
            ctl_oe_d[CTL_INIT] = prn_ctl_req[PCTL_INIT];
            ctl_oe_d[CTL_AUTOFEED] = prn_ctl_req[PCTL_AUTOFEED];
            ctl_oe_d[CTL_STROBE] = prn_ctl_req[PCTL_STROBE];
        end
        else
        begin
            // Open-drain copies for drive B; drive A uses data pins 6, 7 in dual
            ctl_oe_d[CTL_SELECT] = ~lvl[FO_WGATE];
            ctl_oe_d[CTL_PAPER_END] = ~lvl[FO_WSTREAM];
            ctl_oe_d[CTL_BUSY] = ~lvl[FO_MOTOR_B];
            ctl_oe_d[CTL_ACK] = ~lvl[FO_SEL_B];
            ctl_oe_d[CTL_ERROR] = ~lvl[FO_HEAD];
            ctl_oe_d[CTL_SELECT_IN] = ~lvl[FO_STEP];
            ctl_oe_d[CTL_INIT] = ~lvl[FO_SEEK];
            ctl_oe_d[CTL_AUTOFEED] = ~lvl[FO_DENSITY0];
            ctl_oe_d[CTL_STROBE] = 1'b0; // Floats in external modes
        end
    end

    // Control pin registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ctl_oe_q <= '0;
        end
        else
        begin
            ctl_oe_q <= ctl_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Floppy status to controller

    logic [ST_W-1:0] st_q;
    logic [ST_W-1:0] st_d;
    logic fdd_pu_q;
    logic fdd_pu_d;

    // Native status, wired-AND with external in ext modes
    always_comb
    begin
        st_d = fdd_s;
        fdd_pu_d = ~pullup_off_q;
        if (ext_mode)
        begin
            st_d[ST_INDEX] = fdd_s[ST_INDEX] & pd_s[ST_INDEX];
            st_d[ST_TRACK_ZERO] =
                fdd_s[ST_TRACK_ZERO] & pd_s[ST_TRACK_ZERO];
            st_d[ST_WPROT] = fdd_s[ST_WPROT] & pd_s[ST_WPROT];
            st_d[ST_READ] = fdd_s[ST_READ] & pd_s[ST_READ];
            st_d[ST_MEDIA_CHG] =
                fdd_s[ST_MEDIA_CHG] & pd_s[ST_MEDIA_CHG];
        end
    end

    // Status registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_q <= ST_IDLE;
            fdd_pu_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            fdd_pu_q <= fdd_pu_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Printer status to printer core

    logic [PD_W-1:0] prn_in_q;
    logic [PD_W-1:0] prn_in_d;
    logic [PS_W-1:0] ps_q;
    logic [PS_W-1:0] ps_d;

    // Follow pins in printer mode, hold in external modes
    always_comb
    begin
        prn_in_d = prn_in_q;
        ps_d = ps_q;
        if (!ext_mode)
        begin
            prn_in_d = pd_s;
            ps_d = ctl_s[PS_W-1:0];
        end
    end

    // Printer status registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            prn_in_q <= '0;
            ps_q <= PS_RST;
        end
        else
        begin
            prn_in_q <= prn_in_d;
            ps_q <= ps_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Control and floppy pins drive low when enabled; data pins drive prn_data_out in printer mode
    assign pd_out = pd_out_q;
    assign pd_oe = pd_oe_q;
    assign pd_pullup_en = pd_pu_q;
    assign ctl_out = '0;
    assign ctl_oe = ctl_oe_q;
    assign fdd_out = '0;
    assign fdd_oe = fdd_oe_q;
    assign fdd_pullup_en = fdd_pu_q;
    assign fdc_status_n = st_q;
    assign prn_data_in = prn_in_q;
    assign prn_status = ps_q;
    assign port_mode = mode_q;

endmodule

// ===== dv/pin_share_checker_assertions.sv
`timescale 1ns/1ps

module pin_share_checker
    import pin_share_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [CFG_W-1:0] port_mode_cfg,
    input wire logic [CFG_W-1:0] port_mode_cfg_ext,
    input wire logic [CFG_W-1:0] floppy_cfg_reg,
    input wire logic [PD_W-1:0] prn_data_out,
    input wire logic prn_data_drive,
    input wire logic [FO_W-1:0] fdc_req,
    input wire logic [PD_W-1:0] pd_in,
    input wire logic [PD_W-1:0] pd_out,
    input wire logic [PD_W-1:0] pd_oe,
    input wire logic [PD_W-1:0] pd_pullup_en,
    input wire logic [PD_W-1:0] prn_data_in,
    input wire logic [ST_W-1:0] fdd_status_in,
    input wire logic [ST_W-1:0] fdc_status_n,
    input wire logic [FO_W-1:0] fdd_out,
    input wire logic [FO_W-1:0] fdd_oe,
    input wire logic [CTL_W-1:0] ctl_oe,
    input wire logic fdd_pullup_en,
    input wire logic [1:0] port_mode
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic ok;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Settle counter after reset release
    always_comb cnt_d = !rst_n ? 3'h0 : (ok ? cnt_q : cnt_q + 3'h1);
    always_ff @(posedge ref_clk) cnt_q <= cnt_d;
    assign ok = (cnt_q == 3'h7);

    ////////////////////////////////
    // Pin mux relations
    a_mode_decode: assert property (
        ok |-> port_mode == (($past(port_mode_cfg) != CFG_EXT_SEL) ? 2'h0
            : ($past(port_mode_cfg_ext[EXT_DUAL_BIT]) ? 2'h2 : 2'h1)))
        else $error("mode decode wrong");
    a_printer_drive: assert property (
        ok && $past(port_mode) == 2'h0 |-> pd_oe == {8{$past(prn_data_drive)}}
            && pd_out == $past(prn_data_out))
        else $error("printer data drive wrong");
    a_pins_float: assert property (
        ok && $past(port_mode) == 2'h1 |-> pd_oe == 8'h00)
        else $error("single mode pin driven");
    a_dual_motor: assert property (
        ok && $past(port_mode) == 2'h2 |-> pd_oe[5:0] == 6'h00
            && pd_oe[7:6] == {$past(fdc_req[FO_SEL_A]),
            $past(fdc_req[FO_MOTOR_A])} && pd_out[7:6] == 2'h0)
        else $error("dual mode pins wrong");
    a_native_follow: assert property (
        ok |-> fdd_oe == $past(fdc_req) && fdd_out == 10'h000)
        else $error("native pins wrong");
    a_step_copy: assert property (
        ok && $past(port_mode) != 2'h0 |-> !ctl_oe[CTL_STROBE]
            && ctl_oe[CTL_SELECT_IN] == $past(fdc_req[FO_STEP])
            && ctl_oe[CTL_INIT] == $past(fdc_req[FO_SEEK]))
        else $error("control copy wrong");
    a_pullup_ctl: assert property (
        ok && $past(port_mode) != 2'h0 && $stable(port_mode)
            && $past(floppy_cfg_reg[7], 2) == $past(floppy_cfg_reg[7])
            |-> pd_pullup_en[4:0] == {5{~$past(floppy_cfg_reg[7])}}
            && fdd_pullup_en == ~$past(floppy_cfg_reg[7]))
        else $error("pull-up control wrong");
    a_status_merge: assert property (
        ok && $past(port_mode) != 2'h0
            && $past(port_mode, 4) == $past(port_mode)
            |-> fdc_status_n == ($past(fdd_status_in, 3)
            & $past(pd_in[ST_W-1:0], 3)))
        else $error("status merge wrong");
    a_printer_capture: assert property (
        ok && $past(port_mode) == 2'h0 && $past(port_mode, 4) == 2'h0
            |-> prn_data_in == $past(pd_in, 3))
        else $error("printer capture wrong");

    // Main scenarios reached
    c_dual: cover property (port_mode == 2'h2 && pd_oe[6]);
    c_trk0: cover property (port_mode == 2'h1 && !fdc_status_n[1]);
    c_pu_off: cover property (!fdd_pullup_en);
endmodule

bind printer_port_floppy_pin_share pin_share_checker pin_share_checker_i (
    .ref_clk, .rst_n, .port_mode_cfg, .port_mode_cfg_ext, .floppy_cfg_reg,
    .prn_data_out, .prn_data_drive, .fdc_req, .pd_in, .pd_out, .pd_oe,
    .pd_pullup_en, .prn_data_in, .fdd_status_in, .fdc_status_n, .fdd_out,
    .fdd_oe, .ctl_oe, .fdd_pullup_en, .port_mode
);

// ===== dv/ext_drive_model.sv
`timescale 1ns/1ps

module ext_drive_model #(
    parameter int START_TRK = 2,
    parameter bit WP_ON = 1'b1
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic step_lvl,
    input wire logic seek_lvl,
    output logic [4:0] st_low
);
    logic [7:0] trk_q;
    logic [3:0] ph_q;
    logic step_q;
    logic chg_q;

    // Head position, disk rotation, change latch
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            trk_q <= 8'(START_TRK);
            ph_q <= 4'h0;
            step_q <= 1'b1;
            chg_q <= 1'b1;
        end
        else
        begin
            ph_q <= ph_q + 4'h1;
            step_q <= step_lvl;
            if (step_q && !step_lvl)
            begin
                chg_q <= 1'b0;
                if (!seek_lvl)
                    trk_q <= trk_q + 8'h01;
                else if (trk_q != 8'h00)
                    trk_q <= trk_q - 8'h01;
            end
        end
    end

    // Active-low status lines, bit order as status bus
    assign st_low = {chg_q, ph_q[1:0] == 2'h0, WP_ON,
        trk_q == 8'h00, ph_q < 4'h2};
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps

module testbench
    import pin_share_pkg::*;
;
    logic ref_clk = 0, rst_n = 0, prn_data_drive = 0, flt = 0;
    logic prn_on = 1, drv_on = 0, fdd_pullup_en;
    logic [7:0] port_mode_cfg = 0, port_mode_cfg_ext = 0, floppy_cfg_reg = 0;
    logic [7:0] prn_data_out = 0, ptr_data = 0, ext_low, prn_data_in;
    logic [7:0] pd_in, pd_out, pd_oe, pd_pullup_en;
    logic [3:0] prn_ctl_req = 0;
    logic [4:0] prn_status, fdc_status_n, fdd_status_in, st_low;
    logic [9:0] fdc_req = 0, fdd_out, fdd_oe;
    logic [8:0] ctl_in, ctl_out, ctl_oe;
    logic [1:0] port_mode;
    int err_total = 0, checks_done = 0;

    // Clock and undriven-line pattern
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) flt <= ~flt;

    // Wire levels of shared and control pins
    assign ext_low = drv_on ? {3'h0, st_low} : 8'h00;
    assign pd_in = (pd_oe & pd_out) | (~pd_oe & (prn_on ? ptr_data
        : ~ext_low & (pd_pullup_en | {8{flt}})));
    assign ctl_in = ~ctl_oe | ctl_out;
    assign fdd_status_in = {5{fdd_pullup_en | flt}};

    printer_port_floppy_pin_share printer_port_floppy_pin_share_i (
        .ref_clk, .rst_n, .port_mode_cfg, .port_mode_cfg_ext, .floppy_cfg_reg,
        .prn_data_out, .prn_data_drive, .prn_ctl_req, .prn_data_in,
        .prn_status, .fdc_req, .fdc_status_n, .pd_in, .pd_out, .pd_oe,
        .pd_pullup_en, .ctl_in, .ctl_out, .ctl_oe, .fdd_out, .fdd_oe,
        .fdd_status_in, .fdd_pullup_en, .port_mode
    );
    ext_drive_model ext_drive_model_i (.ref_clk, .rst_n, .st_low,
        .step_lvl(ctl_in[CTL_SELECT_IN]), .seek_lvl(ctl_in[CTL_INIT]));

    ////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        if (err_total == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wait_low(input int b);
        int n;
        n = 0;
        while (fdc_status_n[b] !== 1'b0 && n < 40)
        begin
            tick(1);
            n++;
        end
        chk({15'h0, fdc_status_n[b]}, 16'h0000);
    endtask

    task automatic step_once;
        fdc_req[FO_STEP] = 1'b1;
        tick(1);
        chk({15'h0, ctl_oe[CTL_SELECT_IN]}, 16'h0001);
        fdc_req[FO_STEP] = 1'b0;
        tick(3);
    endtask

    ////////////////////////////////
    task automatic t_printer;
        prn_data_out = 8'ha5;
        prn_data_drive = 1'b1;
        prn_ctl_req = 4'h6;
        ptr_data = 8'h3c;
        tick(2);
        chk({pd_oe, pd_out}, 16'hffa5);
        chk({7'h0, ctl_oe}, 16'h00c0);
        prn_data_drive = 1'b0;
        prn_ctl_req = 4'h0;
        tick(5);
        chk({3'h0, prn_status, prn_data_in}, 16'h1f3c);
        chk({11'h0, fdc_status_n}, 16'h001f);
    endtask

    task automatic t_single;
        prn_on = 1'b0;
        drv_on = 1'b1;
        port_mode_cfg = CFG_EXT_SEL;
        tick(2);
        chk({6'h0, port_mode, pd_oe}, 16'h0100);
        chk({11'h0, pd_pullup_en[4:0]}, 16'h001f);
        tick(3);
        chk({13'h0, fdc_status_n[4], fdc_status_n[2:1]},
            16'h0001);
        repeat (2) step_once;
        tick(4);
        chk({14'h0, fdc_status_n[4], fdc_status_n[1]},
            16'h0002);
        wait_low(ST_INDEX);
        wait_low(ST_READ);
    endtask

    task automatic t_dual;
        port_mode_cfg_ext = 8'h01;
        fdc_req[FO_MOTOR_A] = 1'b1;
        fdc_req[FO_SEL_A] = 1'b1;
        tick(2);
        chk({port_mode, pd_oe[7:6], pd_out[7:6]},
            16'h002c);
        port_mode_cfg_ext = 8'h00;
        tick(2);
        chk({14'h0, pd_oe[7:6]}, 16'h0000);
        port_mode_cfg = 8'h02;
        tick(2);
        chk({6'h0, port_mode, pd_oe}, 16'h0000);
        fdc_req = 10'h000;
    endtask

    task automatic t_pullup;
        port_mode_cfg = CFG_EXT_SEL;
        floppy_cfg_reg = 8'h80;
        tick(2);
        chk({10'h0, pd_pullup_en[4:0], fdd_pullup_en}, 16'h0000);
        floppy_cfg_reg = 8'h00;
        tick(2);
        chk({10'h0, pd_pullup_en[4:0], fdd_pullup_en}, 16'h003f);
    endtask

    task automatic t_native;
        logic [12:0] held;
        logic [8:0] ctl_exp [FO_W] = '{9'h080, 9'h010, 9'h001, 9'h002,
            9'h020, 9'h040, 9'h004, 9'h000, 9'h008, 9'h000};
        held = {prn_status, prn_data_in};
        for (int i = 0; i < FO_W; i++)
        begin
            fdc_req = 10'h001 << i;
            tick(1);
            chk({6'h0, fdd_oe}, 16'h0001 << i);
            chk({6'h0, fdd_out}, 16'h0000);
            chk({7'h0, ctl_oe}, {7'h0, ctl_exp[i]});
            chk({7'h0, ctl_out}, 16'h0000);
            chk({3'h0, prn_status, prn_data_in}, {3'h0, held});
        end
        fdc_req = 10'h000;
    endtask

    // Main sequence
    initial
    begin
        tick(4);
        rst_n = 1'b1;
        tick(8);
        t_printer();
        t_single();
        t_dual();
        t_pullup();
        t_native();
        tick(2);
        complete_run();
    end

    // Watchdog
    initial
    begin
        #4000;
        err_total++;
        complete_run();
    end
endmodule
